// [cit_map.svh]
`ifndef CIT_MAP_SVH
`define CIT_MAP_SVH
// ********************************
// Opcodes with fixed meaning
// ********************************
`define CIT_OPC_NOP   8'h00
`define CIT_OPC_SPARE 8'hA5
`define CIT_OPC_TSTCLR 8'h10
// ********************************
// Operand field positions
// ********************************
`define CIT_SFR_BIT   7
`define CIT_PAGE_LSB  11
// ********************************
// Timing counts in system clocks
// ********************************
`define CIT_CNT_RST   4'h0
`define CIT_CNT_LAST  4'h1
`define CIT_CYC_MUL   4'h4
`define CIT_CYC_DIV   4'h8
`define CIT_CYC_RET   4'h5
`define CIT_CYC_LONG  4'h4
`endif

// [cit_pkg.sv]
package cit_pkg;
  // Transfer kind of one decoded opcode
  typedef enum logic [6:0] {
    CIT_K_PLAIN = 7'h01,
    CIT_K_COND  = 7'h02,
    CIT_K_REL   = 7'h04,
    CIT_K_PAGE  = 7'h08,
    CIT_K_LONG  = 7'h10,
    CIT_K_INDEX = 7'h20,
    CIT_K_RET   = 7'h40
  } cit_kind_t;

  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cyc;
    cit_kind_t  kind;
  } cit_dec_t;

  typedef struct packed {
    logic [3:0]  cnt;
    logic        busy;
    logic        done;
    logic [1:0]  len;
    logic [3:0]  cyc;
    logic        taken;
    logic        tgt_valid;
    logic [15:0] target;
    logic [4:0]  reg_addr;
    logic [7:0]  indir_addr;
    logic [7:0]  direct_addr;
    logic        direct_sfr;
    logic        bit_clear;
  } cit_state_t;
endpackage : cit_pkg

// [cit_decoder.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cit_map.svh"

// Function
// - Accumulator clear, complement, rotates and nibble swap: one byte, one cycle.
// - Direct-to-direct and immediate-to-direct moves: three bytes, three cycles.
// - Indirect RAM moves take two cycles even when one byte long.
// - Data pointer immediate load: three bytes, three cycles.
// - Code read into accumulator via data pointer or PC: one byte, three cycles.
// - External data moves, 8-bit or 16-bit address: one byte, three cycles.
// - Stack push and pop of a direct byte: two bytes, two cycles.
// - Exchange: bank register one cycle; direct, indirect, low nibble two.
// - Carry-only ops one byte one cycle; direct-bit ops two bytes two cycles.
// - Carry and zero jumps: two bytes, two cycles not taken, three taken.
// - Direct-bit jumps: three bytes, three or four; test-clear clears set bit.
// - Short, absolute, indexed jumps three; long four; returns five cycles.
// - Compare-jump: three bytes; 3/4 cycles, indirect form 4/5.
// - Decrement-jump: bank register 2 bytes 2/3; direct 3 bytes 3/4.
// - No-operation and the spare opcode: one byte, one cycle, same behaviour.
// - Bank register operand selects one of eight in the current bank.
// - Indirect address comes only from pointer register zero or one.
// - Relative offset is signed 8-bit, added to next instruction address.
// - Direct address below 0x80 is RAM, from 0x80 up is special register.
// - Absolute target replaces low 11 bits within the next-instruction page.
// - Long transfers carry a full 16-bit target.
// - Conditional branches finish one cycle sooner when not taken.
// - All timing counted in plain system clock cycles.
module cit_decoder (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Instruction issue
  input  wire logic        issue,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  op1,
  input  wire logic [7:0]  op2,
  input  wire logic [15:0] next_pc,
  // Datapath state
  input  wire logic [7:0]  acc,
  input  wire logic        carry,
  input  wire logic        bit_val,
  input  wire logic [7:0]  opnd_val,
  input  wire logic [15:0] data_pointer,
  input  wire logic [1:0]  bank_sel,
  input  wire logic [7:0]  ptr0,
  input  wire logic [7:0]  ptr1,
  // Timing
  output logic             busy,
  output logic             done,
  output logic [1:0]       ins_len,
  output logic [3:0]       ins_cycles,
  // Branch
  output logic             taken,
  output logic             tgt_valid,
  output logic [15:0]      branch_target,
  // Operands
  output logic [4:0]       bank_register,
  output logic [7:0]       indirect_pointer_register,
  output logic [7:0]       direct_addr,
  output logic             direct_sfr,
  output logic             bit_clear
);
  import cit_pkg::*;

  // ********************************
  // Decode table
  // ********************************
  function automatic cit_dec_t mk(input logic [1:0] l, input logic [3:0] c,
                                  input cit_kind_t k);
    cit_dec_t d;
    d.len  = l;
    d.cyc  = c;
    d.kind = k;
    return d;
  endfunction : mk

  // First match wins, so exact opcodes stand above the column patterns
  function automatic cit_dec_t decode(input logic [7:0] opc);
    cit_dec_t d;
    d = mk(2'h1, 4'h1, CIT_K_PLAIN);
    casez (opc)
      `CIT_OPC_NOP, `CIT_OPC_SPARE:
        d = mk(2'h1, 4'h1, CIT_K_PLAIN);
      8'h02, 8'h12:
        d = mk(2'h3, `CIT_CYC_LONG, CIT_K_LONG);
      8'h22, 8'h32:
        d = mk(2'h1, `CIT_CYC_RET, CIT_K_RET);
      8'h10, 8'h20, 8'h30:
        d = mk(2'h3, 4'h3, CIT_K_COND);
      8'h40, 8'h50, 8'h60, 8'h70:
        d = mk(2'h2, 4'h2, CIT_K_COND);
      8'h80:
        d = mk(2'h2, 4'h3, CIT_K_REL);
      8'h73:
        d = mk(2'h1, 4'h3, CIT_K_INDEX);
      8'h83, 8'h93:
        d = mk(2'h1, 4'h3, CIT_K_PLAIN);
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
        d = mk(2'h1, 4'h3, CIT_K_PLAIN);
      8'h90:
        d = mk(2'h3, 4'h3, CIT_K_PLAIN);
      8'h75, 8'h85:
        d = mk(2'h3, 4'h3, CIT_K_PLAIN);
      8'h43, 8'h53, 8'h63:
        d = mk(2'h3, 4'h3, CIT_K_PLAIN);
      8'hB4, 8'hB5, 8'b1011_1???:
        d = mk(2'h3, 4'h3, CIT_K_COND);
      8'hB6, 8'hB7:
        d = mk(2'h3, 4'h4, CIT_K_COND);
      8'hD5:
        d = mk(2'h3, 4'h3, CIT_K_COND);
      8'b1101_1???:
        d = mk(2'h2, 4'h2, CIT_K_COND);
      8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2, 8'hB0, 8'hB2, 8'hC2, 8'hD2:
        d = mk(2'h2, 4'h2, CIT_K_PLAIN);
      8'hC0, 8'hD0:
        d = mk(2'h2, 4'h2, CIT_K_PLAIN);
      8'h42, 8'h52, 8'h62:
        d = mk(2'h2, 4'h2, CIT_K_PLAIN);
      8'h84:
        d = mk(2'h1, `CIT_CYC_DIV, CIT_K_PLAIN);
      8'hA4:
        d = mk(2'h1, `CIT_CYC_MUL, CIT_K_PLAIN);
      8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94:
        d = mk(2'h2, 4'h2, CIT_K_PLAIN);
      8'b???0_0001, 8'b???1_0001:
        d = mk(2'h2, 4'h3, CIT_K_PAGE);
      8'b0111_011?, 8'b1000_011?, 8'b1010_011?:
        d = mk(2'h2, 4'h2, CIT_K_PLAIN);
      8'b0111_1???, 8'b1000_1???, 8'b1010_1???:
        d = mk(2'h2, 4'h2, CIT_K_PLAIN);
      8'b????_0101:
        d = mk(2'h2, 4'h2, CIT_K_PLAIN);
      8'b????_011?:
        d = mk(2'h1, 4'h2, CIT_K_PLAIN);
      default:
        d = mk(2'h1, 4'h1, CIT_K_PLAIN);
    endcase
    return d;
  endfunction : decode

  // ********************************
  // Branch condition
  // ********************************
  // Operand value comes from the datapath in the issue cycle
  function automatic logic cond_of(input logic [7:0] opc, input logic [7:0] a,
                                   input logic c, input logic b,
                                   input logic [7:0] v, input logic [7:0] imm);
    logic r;
    r = 1'b0;
    casez (opc)
      8'h10, 8'h20: r = b;
      8'h30:        r = !b;
      8'h40:        r = c;
      8'h50:        r = !c;
      8'h60:        r = (a == 8'h00);
      8'h70:        r = (a != 8'h00);
      8'hB4:        r = (a != imm);
      8'hB5:        r = (a != v);
      8'b1011_011?, 8'b1011_1???:
                    r = (v != imm);
      8'hD5, 8'b1101_1???:
                    r = (v != 8'h01);
      default:      r = 1'b0;
    endcase
    return r;
  endfunction : cond_of

  // ********************************
  // State
  // ********************************
  cit_state_t st_ff;
  cit_state_t nxt_st;
  cit_dec_t   dec;
  logic       accept;
  logic       cond;
  logic [7:0] rel;
  logic       is_taken;

  // Issue is taken in the last busy cycle too, so instructions chain gap-free
  assign accept   = issue && (!st_ff.busy || st_ff.done);
  assign dec      = decode(opcode);
  assign cond     = cond_of(opcode, acc, carry, bit_val, opnd_val, op1);
  assign rel      = (dec.len == 2'h3) ? op2 : op1;
  assign is_taken = (dec.kind == CIT_K_COND) ? cond : (dec.kind != CIT_K_PLAIN);

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.bit_clear = 1'b0;
    if (accept) begin
      nxt_st.len       = dec.len;
      nxt_st.cyc       = dec.cyc + {3'h0, (dec.kind == CIT_K_COND) && cond};
      nxt_st.cnt       = nxt_st.cyc;
      nxt_st.taken     = is_taken;
      nxt_st.tgt_valid = is_taken && (dec.kind != CIT_K_RET);
      case (dec.kind)
        CIT_K_COND, CIT_K_REL:
          nxt_st.target = next_pc + {{8{rel[7]}}, rel};
        CIT_K_PAGE:
          nxt_st.target = {next_pc[15:`CIT_PAGE_LSB], opcode[7:5], op1};
        CIT_K_LONG:
          nxt_st.target = {op1, op2};
        CIT_K_INDEX:
          nxt_st.target = data_pointer + {8'h00, acc};
        default:
          nxt_st.target = st_ff.target;
      endcase
      nxt_st.reg_addr    = {bank_sel, opcode[2:0]};
      nxt_st.indir_addr  = opcode[0] ? ptr1 : ptr0;
      nxt_st.direct_addr = op1;
      nxt_st.direct_sfr  = op1[`CIT_SFR_BIT];
      nxt_st.bit_clear   = (opcode == `CIT_OPC_TSTCLR) && bit_val;
    end else if (st_ff.cnt != `CIT_CNT_RST) begin
      nxt_st.cnt = st_ff.cnt - 4'h1;
    end
    nxt_st.busy = (nxt_st.cnt != `CIT_CNT_RST);
    nxt_st.done = (nxt_st.cnt == `CIT_CNT_LAST);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign busy                      = st_ff.busy;
  assign done                      = st_ff.done;
  assign ins_len                   = st_ff.len;
  assign ins_cycles                = st_ff.cyc;
  assign taken                     = st_ff.taken;
  assign tgt_valid                 = st_ff.tgt_valid;
  assign branch_target             = st_ff.target;
  assign bank_register             = st_ff.reg_addr;
  assign indirect_pointer_register = st_ff.indir_addr;
  assign direct_addr               = st_ff.direct_addr;
  assign direct_sfr                = st_ff.direct_sfr;
  assign bit_clear                 = st_ff.bit_clear;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  acc_ops_one_a: assert property (
    accept && (opcode inside {8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4})
    |=> done && ins_len == 2'h1 && ins_cycles == 4'h1)
    else $error("accumulator op not single cycle");

  dir_move_three_a: assert property (
    accept && (opcode == 8'h85 || opcode == 8'h75)
    |=> ins_len == 2'h3 && !done ##1 !done ##1 done)
    else $error("direct move not three cycles");

  indir_move_two_a: assert property (
    accept && (opcode inside {8'hE6, 8'hE7, 8'hF6, 8'hF7})
    |=> !done && ins_len == 2'h1 ##1 done)
    else $error("indirect move not two cycles");

  ext_move_three_a: assert property (
    accept && (opcode inside {8'hE0, 8'hE2, 8'hF0, 8'hF3, 8'h83, 8'h93})
    |=> ins_len == 2'h1 && ins_cycles == 4'h3 ##2 done)
    else $error("code or external move not three cycles");

  carry_jump_a: assert property (
    accept && opcode == 8'h40
    |=> taken == $past(carry) && ins_cycles == ($past(carry) ? 4'h3 : 4'h2))
    else $error("carry jump timing wrong");

  test_clear_a: assert property (
    accept && opcode == `CIT_OPC_TSTCLR && bit_val |=> bit_clear && taken)
    else $error("test-and-clear did not clear");

  return_five_a: assert property (
    accept && opcode == 8'h22 |=> busy [*4] ##1 done)
    else $error("return not five cycles");

  spare_nop_a: assert property (
    accept && opcode == `CIT_OPC_SPARE |=> done && !taken && ins_len == 2'h1)
    else $error("spare opcode differs from no-operation");

  bank_reg_a: assert property (
    accept && opcode[7:3] == 5'h1D |=> bank_register == {$past(bank_sel), $past(opcode[2:0])})
    else $error("bank register address wrong");

  rel_target_a: assert property (
    accept && opcode == 8'h80
    |=> branch_target == $past(next_pc) + {{8{$past(op1[7])}}, $past(op1)})
    else $error("relative target wrong");

  page_target_a: assert property (
    accept && opcode[4:0] == 5'b0_0001
    |=> branch_target == {$past(next_pc[15:11]), $past(opcode[7:5]), $past(op1)} && tgt_valid)
    else $error("absolute target left its page");

  direct_space_a: assert property (
    accept |=> direct_sfr == $past(op1[7]))
    else $error("direct space select wrong");

  compare_jump_unequal_indirect_a: assert property (
    accept && opcode == 8'hB6 && opnd_val != op1 |=> ins_cycles == 4'h5 ##4 done)
    else $error("indirect compare-jump timing wrong");

  pointer_load_a: assert property (
    accept && opcode == 8'h90 |=> ins_len == 2'h3 && ins_cycles == 4'h3 ##2 done)
    else $error("data pointer load not three cycles");

  stack_two_a: assert property (
    accept && (opcode == 8'hC0 || opcode == 8'hD0) |=> ins_len == 2'h2 && !done ##1 done)
    else $error("push or pop not two cycles");

  bank_exchange_a: assert property (
    accept && opcode[7:3] == 5'h19 |=> done && ins_len == 2'h1 && ins_cycles == 4'h1)
    else $error("bank register exchange not one cycle");

  bit_ops_two_a: assert property (
    accept && (opcode inside {8'hC2, 8'hD2, 8'hB2, 8'hA2, 8'h92})
    |=> ins_len == 2'h2 && ins_cycles == 4'h2 && !done ##1 done)
    else $error("direct bit op not two cycles");

  dec_jump_bank_a: assert property (
    accept && opcode[7:3] == 5'h1B
    |=> ins_len == 2'h2 && ins_cycles == (($past(opnd_val) != 8'h01) ? 4'h3 : 4'h2))
    else $error("bank decrement-jump timing wrong");

  indir_pointer_a: assert property (
    accept && opcode[3:1] == 3'h3
    |=> indirect_pointer_register == ($past(opcode[0]) ? $past(ptr1) : $past(ptr0)))
    else $error("indirect pointer select wrong");

  long_target_a: assert property (
    accept && (opcode == 8'h02 || opcode == 8'h12)
    |=> branch_target == {$past(op1), $past(op2)} && tgt_valid)
    else $error("long target wrong");

  cov_taken_c:     cover property (accept && dec.kind == CIT_K_COND && cond);
  cov_not_taken_c: cover property (accept && dec.kind == CIT_K_COND && !cond);
  cov_chain_c:     cover property (done && accept);
  cov_long_c:      cover property (accept && dec.kind == CIT_K_LONG);
endmodule : cit_decoder
`default_nettype wire

// [core_instruction_timing_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module core_instruction_timing_tb;
  // ****************
  // Bench signals
  // ****************
  logic        sys_clk, rst_b, issue, carry, bit_val, pend;
  logic        busy, done, taken, tgt_valid, direct_sfr, bit_clear, e_tk, e_tv, e_bc;
  logic [7:0]  opcode, op1, op2, acc, opnd_val, ptr0, ptr1, e_op, e_ind, e_dir;
  logic [7:0]  indirect_pointer_register, direct_addr;
  logic [15:0] next_pc, data_pointer, branch_target, e_tgt;
  logic [1:0]  bank_sel, ins_len, e_len;
  logic [3:0]  ins_cycles, e_cyc;
  logic [4:0]  bank_register, e_bank;
  logic [31:0] rng;
  int          err_total, cmp_count;
  logic [7:0]  ops [59] = '{8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'h85, 8'h75,
    8'hE6, 8'hF6, 8'h90, 8'h93, 8'h83, 8'hE2, 8'hF2, 8'hE0, 8'hF0, 8'hC0, 8'hD0, 8'hC8,
    8'hC5, 8'hC6, 8'hD6, 8'hC3, 8'hD3, 8'hB3, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72,
    8'hA0, 8'hA2, 8'h92, 8'h40, 8'h50, 8'h60, 8'h70, 8'h20, 8'h30, 8'h10, 8'h11, 8'h12,
    8'h22, 8'h32, 8'h01, 8'h02, 8'h80, 8'h73, 8'hB4, 8'hB5, 8'hB8, 8'hB6, 8'hD8, 8'hD5,
    8'h00, 8'hA5};

  cit_decoder i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .issue(issue), .opcode(opcode),
    .op1(op1), .op2(op2), .next_pc(next_pc), .acc(acc), .carry(carry), .bit_val(bit_val),
    .opnd_val(opnd_val), .data_pointer(data_pointer), .bank_sel(bank_sel), .ptr0(ptr0),
    .ptr1(ptr1), .busy(busy), .done(done), .ins_len(ins_len), .ins_cycles(ins_cycles),
    .taken(taken), .tgt_valid(tgt_valid), .branch_target(branch_target),
    .bank_register(bank_register), .indirect_pointer_register(indirect_pointer_register),
    .direct_addr(direct_addr), .direct_sfr(direct_sfr), .bit_clear(bit_clear));

  // ****************
  // Reference model
  // ****************
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  // Length, base cycles, transfer class (1 cond, 2 rel, 3 page, 4 long, 5 index, 6 return)
  function automatic logic [8:0] tab(input logic [7:0] op);
    casez (op)
      8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hC3, 8'hD3, 8'hB3, 8'h00, 8'hA5,
      8'b1100_1???: return {2'h1, 4'h1, 3'h0};
      8'h85, 8'h75, 8'h90: return {2'h3, 4'h3, 3'h0};
      8'b111?011?, 8'b110?011?: return {2'h1, 4'h2, 3'h0};
      8'h93, 8'h83, 8'b111?001?, 8'hE0, 8'hF0: return {2'h1, 4'h3, 3'h0};
      8'hC0, 8'hD0, 8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92:
        return {2'h2, 4'h2, 3'h0};
      8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???: return {2'h2, 4'h2, 3'h1};
      8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'b1011_1???, 8'hD5: return {2'h3, 4'h3, 3'h1};
      8'hB6, 8'hB7: return {2'h3, 4'h4, 3'h1};
      8'h80: return {2'h2, 4'h3, 3'h2};
      8'b????0001: return {2'h2, 4'h3, 3'h3};
      8'h02, 8'h12: return {2'h3, 4'h4, 3'h4};
      8'h73: return {2'h1, 4'h3, 3'h5};
      default: return {2'h1, 4'h5, 3'h6};
    endcase
  endfunction : tab

  function automatic logic met(input logic [7:0] op);
    casez (op)
      8'h40: return carry;
      8'h50: return !carry;
      8'h60: return acc == 8'h00;
      8'h70: return acc != 8'h00;
      8'h20, 8'h10: return bit_val;
      8'h30: return !bit_val;
      8'hB4: return acc != op1;
      8'hB5: return acc != opnd_val;
      8'hD5, 8'b1101_1???: return opnd_val != 8'h01;
      default: return opnd_val != op1;
    endcase
  endfunction : met

  // ****************
  // Checks and drivers
  // ****************
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  // Outputs other than busy, done and bit_clear hold until the next accept, so they are judged in the last cycle
  task automatic check_prev();
    if (pend) begin
      chk(busy === 1'b1 && done === 1'b1, "done missing");
      chk(ins_len === e_len, "length");
      chk(ins_cycles === e_cyc, "cycles");
      chk(taken === e_tk && tgt_valid === e_tv, "taken");
      if (e_tv) chk(branch_target === e_tgt, "target");
      if (e_op[3]) chk(bank_register === e_bank, "bank reg");
      if (e_op[3:1] == 3'b011) chk(indirect_pointer_register === e_ind, "pointer");
      if (e_op inside {8'h85, 8'h75, 8'hC0, 8'hD0, 8'hC5, 8'hD5, 8'hB5})
        chk(direct_addr === e_dir && direct_sfr === e_dir[7], "direct");
    end else chk(busy === 1'b0 && done === 1'b0, "idle");
    pend = 1'b0;
  endtask : check_prev

  task automatic idle();
    issue <= 1'b0;
    #1;
    check_prev();
    @(posedge sys_clk);
  endtask : idle

  // Entered at a rising edge; returns at the edge of the last cycle
  task automatic run_ins(input logic [7:0] base);
    logic [31:0] r, s, q;
    logic [8:0]  t;
    logic [7:0]  op, rel;
    r = rnd();
    s = rnd();
    q = rnd();
    op = base;
    if (base[3]) op[2:0] = r[2:0];
    else if (base[3:1] == 3'b011 || base[7:5] == 3'b111 && base[3:0] == 4'h2) op[0] = r[0];
    else if (base[3:0] == 4'h1) op[7:5] = r[7:5];
    issue <= 1'b1;
    opcode <= op;
    op1 <= r[15:8];
    op2 <= r[31:24];
    acc <= r[17] ? r[15:8] : (r[16] ? 8'h00 : q[23:16]);
    opnd_val <= r[18] ? r[15:8] : (r[19] ? 8'h01 : q[31:24]);
    {carry, bit_val, bank_sel} <= r[23:20];
    {next_pc, data_pointer} <= s;
    {ptr1, ptr0} <= q[15:0];
    #1;
    check_prev();
    t = tab(op);
    e_op = op;
    e_len = t[8:7];
    e_tk = (t[2:0] == 3'h1) ? met(op) : (t[2:0] != 3'h0);
    e_cyc = t[6:3] + {3'h0, e_tk && t[2:0] == 3'h1};
    e_tv = e_tk && t[2:0] != 3'h6;
    rel = (e_len == 2'h3) ? op2 : op1;
    case (t[2:0])
      3'h3: e_tgt = {next_pc[15:11], op[7:5], op1};
      3'h4: e_tgt = {op1, op2};
      3'h5: e_tgt = data_pointer + {8'h00, acc};
      default: e_tgt = next_pc + {{8{rel[7]}}, rel};
    endcase
    e_bc = op == 8'h10 && bit_val;
    e_bank = {bank_sel, op[2:0]};
    e_ind = op[0] ? ptr1 : ptr0;
    e_dir = op1;
    @(posedge sys_clk);
    for (int i = 1; i < e_cyc; i++) begin
      // A long opcode offered while busy must be refused
      issue <= r[i];
      opcode <= 8'h84;
      #1;
      chk(busy === 1'b1 && done === 1'b0, "early done");
      chk(bit_clear === (i == 1 && e_bc), "bit clear pulse");
      @(posedge sys_clk);
    end
    pend = 1'b1;
  endtask : run_ins

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // ****************
  // Sequence
  // ****************
  always #10 sys_clk = ~sys_clk;

  initial begin
    {sys_clk, rst_b, issue, carry, bit_val, pend} = '0;
    {opcode, op1, op2, acc, opnd_val, ptr0, ptr1} = '0;
    {next_pc, data_pointer, bank_sel} = '0;
    rng = 32'h0001_2105;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    chk({busy, done, taken, tgt_valid, bit_clear, ins_len, ins_cycles} === '0, "reset");
    @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    // Every opcode in ops twice, back to back
    for (int p = 0; p < 2; p++) foreach (ops[k]) run_ins(ops[k]);
    repeat (400) begin
      if (rnd() % 8 == 0) idle();
      else run_ins(ops[rnd() % 59]);
    end
    idle();
    idle();
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    chk(1'b0, "timeout");
    report_and_stop();
  end
endmodule : core_instruction_timing_tb
`default_nettype wire
